/* File: dv/ead_decoder_tb.sv */
// Self-checking testbench for the effective-address decoder
`timescale 1ns/10ps
`default_nettype none
module ead_decoder_tb;
	typedef struct {
		int isr, md, rn, lpb, ea, ext, ac, ra, oc, oa, tot;
	} ead_exp_s;

	// ==========================================================
	// Signals and design instance
	logic core_clk = 0, rst = 1, dec_valid = 0;
	logic branch_valid = 0, access_done = 0;
	logic [4:0] ea_code = 0;
	ead_pkg::ead_size_e op_size = ead_pkg::EAD_SZ_BYTE;
	ead_pkg::ead_bus_e bus_type = ead_pkg::EAD_BUS_INTREG;
	logic [3:0] wait_cycles = 0;
	logic [127:0] wgr = 0;
	logic [15:0] pc = 0, d16 = 0, dir16 = 0;
	logic [7:0] d8 = 0, rel_offset = 0;
	logic out_valid, is_register, long_pair_bad, inc_valid;
	ead_pkg::ead_mode_e mode;
	logic [2:0] reg_num, op_accesses;
	logic [15:0] eff_addr, branch_target, inc_value;
	logic [1:0] ext_bytes, reg_accesses, inc_reg;
	logic [3:0] addr_cycles, op_cycles;
	logic [4:0] total_cycles;
	int mismatches = 0, comparisons = 0;
	ead_exp_s q[$];

	ead_decoder ead_decoder_i (
		.core_clk(core_clk), .rst(rst), .dec_valid(dec_valid),
		.ea_code(ea_code), .op_size(op_size), .bus_type(bus_type),
		.wait_cycles(wait_cycles), .word_general_register(wgr), .pc(pc),
		.short_displacement(d8), .long_displacement(d16),
		.direct_sixteen_bit_address(dir16), .branch_valid(branch_valid),
		.rel_offset(rel_offset), .access_done(access_done),
		.out_valid(out_valid), .is_register(is_register), .mode(mode),
		.reg_num(reg_num), .long_pair_bad(long_pair_bad),
		.eff_addr(eff_addr), .ext_bytes(ext_bytes),
		.addr_cycles(addr_cycles), .reg_accesses(reg_accesses),
		.op_cycles(op_cycles), .op_accesses(op_accesses),
		.total_cycles(total_cycles), .branch_target(branch_target),
		.inc_valid(inc_valid), .inc_reg(inc_reg), .inc_value(inc_value)
	);

	initial begin
		forever #4 core_clk = ~core_clk;
	end

	// ==========================================================
	// Reference model
	function automatic ead_exp_s model(int c, int sz, int bus,
		logic [127:0] r, logic [15:0] p, logic [7:0] s8,
		logic [15:0] l16, logic [15:0] a16, int w);
		ead_exp_s e;
		int m, b, odd;
		e.isr = c < 8;
		e.md = c < 8 ? 0 : c < 12 ? 1 : c < 16 ? 2 : c < 24 ? 3 :
			c < 28 ? 4 : c < 30 ? 5 : c - 24;
		e.rn = e.md == 0 ? (sz == 2 ? c >> 1 : c) :
			(e.md == 3 || e.md > 5) ? c & 7 : e.md == 5 ? c & 1 : c & 3;
		e.lpb = e.md == 0 && sz == 2 && (c & 1);
		case (e.md)
			1, 2: e.ea = r[16*(c&3)+:16];
			3: e.ea = r[16*(c&7)+:16] + {{8{s8[7]}}, s8};
			4: e.ea = r[16*(c&3)+:16] + l16;
			5: e.ea = r[16*(c&1)+:16] + r[112+:16];
			6: e.ea = p + l16;
			7: e.ea = a16;
			default: e.ea = 0;
		endcase
		e.ea = e.ea & 'hffff;
		e.ext = e.md == 3 ? 1 : (e.md == 4 || e.md > 5) ? 2 : 0;
		e.ac = e.md == 0 ? 0 : (e.md == 2 || e.md == 5) ? 4 :
			e.md == 7 ? 1 : 2;
		e.ra = (e.md == 2 || e.md == 5) ? 2 : e.md > 5 ? 0 : 1;
		// Register operands always cost as an internal register
		b = e.isr ? 0 : bus;
		m = sz == 1 ? 1 : 2;
		odd = e.ea & 1;
		if (sz == 0) begin
			e.oc = b >= 2;
			e.oa = 1;
		end else if (b == 3 || (b == 2 && odd)) begin
			e.oc = 4 * m;
			e.oa = 2 * m;
		end else if (b == 1 && odd) begin
			e.oc = 2 * m;
			e.oa = 2 * m;
		end else begin
			e.oc = b == 2 ? m : 0;
			e.oa = m;
		end
		e.tot = e.ac + e.oc + (b >= 2 ? w : 0);
		return e;
	endfunction

	// ==========================================================
	// Drivers and comparisons
	task automatic check(input logic [31:0] seen, input logic [31:0] exp,
		input string what);
		comparisons++;
		if (seen !== exp) begin
			mismatches++;
			$display("BAD t=%0t %s seen %0h exp %0h", $time, what, seen, exp);
		end
	endtask

	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic cmp_out(input ead_exp_s e);
		check(out_valid, 1, "out_valid");
		check(is_register, e.isr, "is_register");
		check(mode, e.md, "mode");
		check(reg_num, e.rn, "reg_num");
		check(ext_bytes, e.ext, "ext_bytes");
		check(addr_cycles, e.ac, "addr_cycles");
		check(op_cycles, e.oc, "op_cycles");
		check(op_accesses, e.oa, "op_accesses");
		check(total_cycles, e.tot, "total_cycles");
		if (e.isr == 0) begin
			check(eff_addr, e.ea, "eff_addr");
			check(reg_accesses, e.ra, "reg_accesses");
		end else begin
			check(long_pair_bad, e.lpb, "long_pair_bad");
		end
	endtask

	// Called just after a rising edge; fresh random operands each time
	task automatic drive(input int c, input int sz, input int bus,
		input logic ad, output ead_exp_s e);
		logic [127:0] r;
		logic [15:0] p, l, a;
		logic [7:0] s;
		logic [3:0] w;
		r = {$urandom, $urandom, $urandom, $urandom};
		p = $urandom;
		l = $urandom;
		a = $urandom;
		s = $urandom;
		w = $urandom;
		e = model(c, sz, bus, r, p, s, l, a, w);
		dec_valid <= 1'b1;
		ea_code <= c[4:0];
		op_size <= ead_pkg::ead_size_e'(sz[1:0]);
		bus_type <= ead_pkg::ead_bus_e'(bus[1:0]);
		wait_cycles <= w;
		wgr <= r;
		pc <= p;
		d8 <= s;
		d16 <= l;
		dir16 <= a;
		access_done <= ad;
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		ead_exp_s e;
		logic [7:0] tbl [5];
		logic [7:0] o;
		logic [15:0] p, t;
		int n, sz;
		tbl = '{8'h00, 8'h01, 8'h7f, 8'h80, 8'hff};
		repeat (20) @(posedge core_clk);
		rst <= 1'b0;
		void'($urandom(32'h7738ebc4));
		// Every code, size and bus back to back
		for (int c = 0; c < 32; c++)
			for (int s = 0; s < 3; s++)
				for (int b = 0; b < 4; b++) begin
					@(posedge core_clk);
					drive(c, s, b, 1'b0, e);
					#1;
					if (q.size() > 0)
						cmp_out(q.pop_front());
					q.push_back(e);
				end
		@(posedge core_clk);
		dec_valid <= 1'b0;
		#1 cmp_out(q.pop_front());
		@(posedge core_clk);
		#1 check(out_valid, 0, "out_valid pulse");
		$display("test decode sweep done");
		// Branch offsets at both signed extremes
		for (int i = 0; i < 8; i++) begin
			o = i < 5 ? tbl[i] : 8'($urandom);
			p = $urandom;
			t = p + {{8{o[7]}}, o};
			@(posedge core_clk);
			branch_valid <= 1'b1;
			rel_offset <= o;
			pc <= p;
			@(posedge core_clk);
			branch_valid <= 1'b0;
			#1 check(branch_target, t, "branch_target");
		end
		$display("test branch done");
		// Completion in the cycle right after the decode
		@(posedge core_clk);
		drive(12, 1, 0, 1'b0, e);
		@(posedge core_clk);
		dec_valid <= 1'b0;
		access_done <= 1'b1;
		#1 cmp_out(e);
		@(posedge core_clk);
		access_done <= 1'b0;
		#1 check(inc_valid, 1, "prompt inc_valid");
		check(inc_reg, e.rn, "prompt inc_reg");
		check(inc_value, (e.ea + 2) & 'hffff, "prompt inc_value");
		// Post-increment: early completion ignored, later decode wins
		for (int k = 0; k < 4; k++) begin
			sz = k % 3;
			@(posedge core_clk);
			drive(12 + k, sz, k, 1'b1, e);
			if (k % 2 == 1) begin
				sz = 2;
				@(posedge core_clk);
				drive(15 - k, sz, 1, 1'b0, e);
			end
			@(posedge core_clk);
			dec_valid <= 1'b0;
			access_done <= 1'b0;
			#1 cmp_out(e);
			repeat (3) begin
				@(posedge core_clk);
				#1 check(inc_valid, 0, "early inc_valid");
			end
			@(posedge core_clk);
			access_done <= 1'b1;
			@(posedge core_clk);
			access_done <= 1'b0;
			#1;
			n = 0;
			while (inc_valid !== 1'b1 && n < 4) begin
				@(posedge core_clk);
				#1;
				n++;
			end
			if (inc_valid !== 1'b1) begin
				mismatches++;
				$display("BAD t=%0t inc_valid timeout", $time);
				break;
			end
			check(inc_reg, e.rn, "inc_reg");
			check(inc_value, (e.ea + (1 << sz)) & 'hffff, "inc_value");
			@(posedge core_clk);
			#1 check(inc_valid, 0, "inc_valid pulse");
		end
		$display("test post-increment done");
		stop_test();
	end
endmodule
`default_nettype wire

/* File: hw/ead_decoder.sv */
// Effective-address decoder with operand cycle accounting
// ==========================================================
// Summary of operation
// - Codes 00-07 pick a register operand; others pick computed memory.
// - Codes 08-1F decode as memory modes of a 5-bit field.
// - Codes 0C-0F use word registers 0-3, then post-increment them.
// - Codes 10-17 add word register 0-7 and one-byte displacement.
// - Codes 18-1B add word register 0-3 and two-byte displacement.
// - 1C is reg0 plus reg7, 1D reg1 plus reg7; no extension.
// - 1E is PC plus 16-bit displacement; 1F a direct address.
// - Extension bytes: 0, 1 or 2 by mode.
// - Address cycles: 0, 2, 4 or 1 by mode.
// - Register accesses: 0, 1 or 2 by mode.
// - Byte operand: one access, +1 cycle on external buses.
// - Word operand cost by internal/16-bit bus and alignment.
// - Long operand cost by alignment, internal or 16-bit bus.
// - 8-bit bus: word two accesses +4, long four +8.
// - External accesses also count inserted wait cycles.
// - Relative branch offset is added to the program counter.
`timescale 1ns/10ps
`default_nettype none
module ead_decoder #(
	parameter int DATA_W = ead_pkg::DATA_W
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic dec_valid,
	input wire logic [4:0] ea_code,
	input wire ead_pkg::ead_size_e op_size,
	input wire ead_pkg::ead_bus_e bus_type,
	input wire logic [3:0] wait_cycles,
	input wire logic [8*DATA_W-1:0] word_general_register,
	input wire logic [DATA_W-1:0] pc,
	input wire logic [7:0] short_displacement,
	input wire logic [DATA_W-1:0] long_displacement,
	input wire logic [DATA_W-1:0] direct_sixteen_bit_address,
	input wire logic branch_valid,
	input wire logic [7:0] rel_offset,
	input wire logic access_done,
	output logic out_valid,
	output logic is_register,
	output ead_pkg::ead_mode_e mode,
	output logic [2:0] reg_num,
	output logic long_pair_bad,
	output logic [DATA_W-1:0] eff_addr,
	output logic [1:0] ext_bytes,
	output logic [3:0] addr_cycles,
	output logic [1:0] reg_accesses,
	output logic [3:0] op_cycles,
	output logic [2:0] op_accesses,
	output logic [4:0] total_cycles,
	output logic [DATA_W-1:0] branch_target,
	output logic inc_valid,
	output logic [1:0] inc_reg,
	output logic [DATA_W-1:0] inc_value
);
	// ==========================================================
	// Combinational decode
	ead_cost_if cost_bus ();
	ead_operand_cost u_cost (.cost(cost_bus.provider));

	logic [DATA_W-1:0] wreg [8];
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_reg
			assign wreg[gi] = word_general_register[gi*DATA_W +: DATA_W];
		end
	endgenerate

	ead_pkg::ead_mode_e mode_next;
	logic [DATA_W-1:0] addr_next;
	logic [1:0] ext_next;
	logic [3:0] acyc_next;
	logic [1:0] racc_next;
	logic [2:0] rnum_next;
	logic [DATA_W-1:0] sdisp;
	logic memory_op;
	logic [2:0] size_bytes;

	assign sdisp = {{(DATA_W-8){short_displacement[7]}}, short_displacement};
	assign memory_op = (ea_code > ead_pkg::EA_REG_LAST);

	always_comb begin
		mode_next = ead_pkg::EAD_MODE_REG;
		addr_next = '0;
		ext_next = ead_pkg::EXT_NONE;
		acyc_next = ead_pkg::CYC_ZERO;
		racc_next = 2'h0;
		rnum_next = ea_code[2:0];
		if (!memory_op) begin
			if (op_size == ead_pkg::EAD_SZ_LONG) begin
				rnum_next = {1'b0, ea_code[2:1]};
			end
		end else if (ea_code <= ead_pkg::EA_IND_LAST) begin
			mode_next = ead_pkg::EAD_MODE_IND;
			addr_next = wreg[ea_code[1:0]];
			acyc_next = ead_pkg::CYC_TWO;
			racc_next = ead_pkg::ACC_ONE[1:0];
			rnum_next = {1'b0, ea_code[1:0]};
		end else if (ea_code <= ead_pkg::EA_INC_LAST) begin
			mode_next = ead_pkg::EAD_MODE_POSTINC;
			addr_next = wreg[ea_code[1:0]];
			acyc_next = ead_pkg::CYC_FOUR;
			racc_next = ead_pkg::ACC_TWO[1:0];
			rnum_next = {1'b0, ea_code[1:0]};
		end else if (ea_code <= ead_pkg::EA_D8_LAST) begin
			mode_next = ead_pkg::EAD_MODE_SDISP;
			addr_next = wreg[ea_code[2:0]] + sdisp;
			ext_next = ead_pkg::EXT_ONE;
			acyc_next = ead_pkg::CYC_TWO;
			racc_next = ead_pkg::ACC_ONE[1:0];
		end else if (ea_code <= ead_pkg::EA_D16_LAST) begin
			mode_next = ead_pkg::EAD_MODE_LDISP;
			addr_next = wreg[ea_code[1:0]] + long_displacement;
			ext_next = ead_pkg::EXT_TWO;
			acyc_next = ead_pkg::CYC_TWO;
			racc_next = ead_pkg::ACC_ONE[1:0];
			rnum_next = {1'b0, ea_code[1:0]};
		end else if (ea_code == ead_pkg::EA_IDX0 ||
			ea_code == ead_pkg::EA_IDX1) begin
			mode_next = ead_pkg::EAD_MODE_INDEX;
			addr_next = wreg[{2'b00, ea_code[0]}] +
				wreg[ead_pkg::INDEX_REG_NUM];
			acyc_next = ead_pkg::CYC_FOUR;
			racc_next = ead_pkg::ACC_TWO[1:0];
			rnum_next = {2'b00, ea_code[0]};
		end else if (ea_code == ead_pkg::EA_PCREL) begin
			mode_next = ead_pkg::EAD_MODE_PCREL;
			addr_next = pc + long_displacement;
			ext_next = ead_pkg::EXT_TWO;
			acyc_next = ead_pkg::CYC_TWO;
		end else begin
			mode_next = ead_pkg::EAD_MODE_DIRECT;
			addr_next = direct_sixteen_bit_address;
			ext_next = ead_pkg::EXT_TWO;
			acyc_next = ead_pkg::CYC_ONE;
		end
	end

	// Register operands cost as internal registers regardless of bus input
	assign cost_bus.size = op_size;
	assign cost_bus.bus = memory_op ? bus_type : ead_pkg::EAD_BUS_INTREG;
	assign cost_bus.odd = addr_next[0];

	logic ext_bus;
	assign ext_bus = memory_op && (bus_type == ead_pkg::EAD_BUS_EXT16 ||
		bus_type == ead_pkg::EAD_BUS_EXT8);

	always_comb begin
		case (op_size)
			ead_pkg::EAD_SZ_BYTE: size_bytes = ead_pkg::SIZE_BYTE;
			ead_pkg::EAD_SZ_WORD: size_bytes = ead_pkg::SIZE_WORD;
			default: size_bytes = ead_pkg::SIZE_LONG;
		endcase
	end

	// ==========================================================
	// Decode result registers
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			out_valid <= 1'b0;
			is_register <= 1'b0;
			mode <= ead_pkg::EAD_MODE_REG;
			reg_num <= 3'h0;
			long_pair_bad <= 1'b0;
			eff_addr <= '0;
			ext_bytes <= 2'h0;
			addr_cycles <= 4'h0;
			reg_accesses <= 2'h0;
			op_cycles <= 4'h0;
			op_accesses <= 3'h0;
			total_cycles <= 5'h0;
		end else begin
			out_valid <= dec_valid;
			if (dec_valid) begin
				is_register <= !memory_op;
				mode <= mode_next;
				reg_num <= rnum_next;
				// Odd code with long type names no distinct pair
				long_pair_bad <= !memory_op && ea_code[0] &&
					op_size == ead_pkg::EAD_SZ_LONG;
				eff_addr <= addr_next;
				ext_bytes <= ext_next;
				addr_cycles <= acyc_next;
				reg_accesses <= racc_next;
				op_cycles <= cost_bus.cycles;
				op_accesses <= cost_bus.accesses;
				// Waits count only when the external bus is really used
				total_cycles <= 5'({1'b0, acyc_next}) +
					5'({1'b0, cost_bus.cycles}) +
					(ext_bus ? 5'({1'b0, wait_cycles}) : 5'h0);
			end
		end
	end

	// ==========================================================
	// Branch target
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			branch_target <= '0;
		end else if (branch_valid) begin
			branch_target <= pc + {{(DATA_W-8){rel_offset[7]}},
				rel_offset};
		end
	end

	// ==========================================================
	// Post-increment writeback
	logic pending_reg;
	logic [1:0] pend_reg_reg;
	logic [DATA_W-1:0] pend_val_reg;

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			pending_reg <= 1'b0;
			pend_reg_reg <= 2'h0;
			pend_val_reg <= '0;
			inc_valid <= 1'b0;
			inc_reg <= 2'h0;
			inc_value <= '0;
		end else begin
			inc_valid <= 1'b0;
			if (dec_valid && mode_next == ead_pkg::EAD_MODE_POSTINC) begin
				pending_reg <= 1'b1;
				pend_reg_reg <= ea_code[1:0];
				pend_val_reg <= addr_next +
					DATA_W'(size_bytes);
			end else if (pending_reg && access_done) begin
				// Update only after the access so the old pointer is used
				pending_reg <= 1'b0;
				inc_valid <= 1'b1;
				inc_reg <= pend_reg_reg;
				inc_value <= pend_val_reg;
			end
		end
	end

	// ==========================================================
	// Checks
	ext_count_a: assert property (
		@(posedge core_clk) disable iff (rst)
		dec_valid && ea_code >= ead_pkg::EA_D8_FIRST &&
		ea_code <= ead_pkg::EA_D8_LAST |=> ext_bytes == ead_pkg::EXT_ONE)
		else $error("short displacement extension count wrong");
	ext_two_a: assert property (
		@(posedge core_clk) disable iff (rst)
		dec_valid && (ea_code == ead_pkg::EA_PCREL ||
		ea_code == ead_pkg::EA_DIRECT) |=> ext_bytes == ead_pkg::EXT_TWO)
		else $error("two-byte extension missing");
	reg_direct_a: assert property (
		@(posedge core_clk) disable iff (rst)
		dec_valid |=>
		is_register == ($past(ea_code) <= ead_pkg::EA_REG_LAST))
		else $error("register direct flag wrong");
	long_pair_a: assert property (
		@(posedge core_clk) disable iff (rst)
		dec_valid && ea_code <= ead_pkg::EA_REG_LAST &&
		op_size == ead_pkg::EAD_SZ_LONG |=>
		reg_num == {1'b0, $past(ea_code[2:1])})
		else $error("long pair number wrong");
	addr_cyc_a: assert property (
		@(posedge core_clk) disable iff (rst)
		dec_valid && ea_code == ead_pkg::EA_DIRECT |=>
		addr_cycles == ead_pkg::CYC_ONE && reg_accesses == 2'h0)
		else $error("direct address cost wrong");
	idx_acc_a: assert property (
		@(posedge core_clk) disable iff (rst)
		dec_valid && ea_code == ead_pkg::EA_IDX1 |=>
		addr_cycles == ead_pkg::CYC_FOUR && reg_accesses == 2'h2 &&
		eff_addr == $past(wreg[1]) + $past(wreg[7]))
		else $error("index mode wrong");
	ext8_cost_a: assert property (
		@(posedge core_clk) disable iff (rst)
		dec_valid && memory_op && bus_type == ead_pkg::EAD_BUS_EXT8 &&
		op_size == ead_pkg::EAD_SZ_LONG |=>
		op_cycles == ead_pkg::CYC_EIGHT && op_accesses == ead_pkg::ACC_FOUR)
		else $error("8-bit bus long cost wrong");
	byte_cost_a: assert property (
		@(posedge core_clk) disable iff (rst)
		dec_valid && memory_op && op_size == ead_pkg::EAD_SZ_BYTE |=>
		op_accesses == ead_pkg::ACC_ONE &&
		op_cycles == (($past(bus_type) == ead_pkg::EAD_BUS_EXT16 ||
		$past(bus_type) == ead_pkg::EAD_BUS_EXT8) ? ead_pkg::CYC_ONE :
		ead_pkg::CYC_ZERO))
		else $error("byte cost wrong");
	word_odd_a: assert property (
		@(posedge core_clk) disable iff (rst)
		dec_valid && memory_op && op_size == ead_pkg::EAD_SZ_WORD &&
		bus_type == ead_pkg::EAD_BUS_EXT16 && addr_next[0] |=>
		op_cycles == ead_pkg::CYC_FOUR && op_accesses == ead_pkg::ACC_TWO)
		else $error("odd word cost on 16-bit bus wrong");
	// Built from the registered fields, so a wrong sum cannot hide
	wait_add_a: assert property (
		@(posedge core_clk) disable iff (rst)
		dec_valid |=> total_cycles == 5'(addr_cycles) + 5'(op_cycles) +
		(($past(ea_code) > ead_pkg::EA_REG_LAST &&
		$past(bus_type) >= ead_pkg::EAD_BUS_EXT16) ?
		5'($past(wait_cycles)) : 5'h0))
		else $error("total cycles wrong");
	inc_size_a: assert property (
		@(posedge core_clk) disable iff (rst)
		dec_valid && ea_code == ead_pkg::EA_INC_FIRST &&
		op_size == ead_pkg::EAD_SZ_WORD ##1 !dec_valid && access_done |=>
		inc_valid && inc_reg == 2'h0 &&
		inc_value == $past(wreg[0], 2) + 16'h0002)
		else $error("post-increment update wrong");
	branch_a: assert property (
		@(posedge core_clk) disable iff (rst)
		branch_valid |=> branch_target ==
		$past(pc) + {{8{$past(rel_offset[7])}}, $past(rel_offset)})
		else $error("branch target wrong");
	cov_pcrel_c: cover property (@(posedge core_clk) disable iff (rst)
		dec_valid && ea_code == ead_pkg::EA_PCREL);
	cov_inc_c: cover property (@(posedge core_clk) inc_valid);
	cov_odd_c: cover property (@(posedge core_clk) disable iff (rst)
		dec_valid && memory_op && addr_next[0] &&
		op_size == ead_pkg::EAD_SZ_LONG);
endmodule
`default_nettype wire

/* File: hw/ead_operand_cost.sv */
// Operand access cost table by width, alignment and bus type
`timescale 1ns/10ps
`default_nettype none
module ead_operand_cost (
	ead_cost_if.provider cost
);
	always_comb begin
		cost.cycles = ead_pkg::CYC_ZERO;
		cost.accesses = ead_pkg::ACC_ONE;
		case (cost.size)
			ead_pkg::EAD_SZ_BYTE: begin
				cost.accesses = ead_pkg::ACC_ONE;
				if (cost.bus == ead_pkg::EAD_BUS_EXT16 ||
					cost.bus == ead_pkg::EAD_BUS_EXT8) begin
					cost.cycles = ead_pkg::CYC_ONE;
				end
			end
			ead_pkg::EAD_SZ_WORD: begin
				case (cost.bus)
					ead_pkg::EAD_BUS_INTREG: begin
						cost.accesses = ead_pkg::ACC_ONE;
					end
					ead_pkg::EAD_BUS_INTMEM: begin
						cost.accesses = cost.odd ? ead_pkg::ACC_TWO : ead_pkg::ACC_ONE;
						cost.cycles = cost.odd ? ead_pkg::CYC_TWO : ead_pkg::CYC_ZERO;
					end
					ead_pkg::EAD_BUS_EXT16: begin
						cost.accesses = cost.odd ? ead_pkg::ACC_TWO : ead_pkg::ACC_ONE;
						cost.cycles = cost.odd ? ead_pkg::CYC_FOUR : ead_pkg::CYC_ONE;
					end
					default: begin
						cost.accesses = ead_pkg::ACC_TWO;
						cost.cycles = ead_pkg::CYC_FOUR;
					end
				endcase
			end
			default: begin
				case (cost.bus)
					ead_pkg::EAD_BUS_INTREG: begin
						cost.accesses = ead_pkg::ACC_TWO;
					end
					ead_pkg::EAD_BUS_INTMEM: begin
						cost.accesses = cost.odd ? ead_pkg::ACC_FOUR : ead_pkg::ACC_TWO;
						cost.cycles = cost.odd ? ead_pkg::CYC_FOUR : ead_pkg::CYC_ZERO;
					end
					ead_pkg::EAD_BUS_EXT16: begin
						cost.accesses = cost.odd ? ead_pkg::ACC_FOUR : ead_pkg::ACC_TWO;
						cost.cycles = cost.odd ? ead_pkg::CYC_EIGHT : ead_pkg::CYC_TWO;
					end
					default: begin
						cost.accesses = ead_pkg::ACC_FOUR;
						cost.cycles = ead_pkg::CYC_EIGHT;
					end
				endcase
			end
		endcase
	end
endmodule
`default_nettype wire

/* File: shared/ead_cost_if.sv */
// Interface: operand access cost query between decoder and cost table
`timescale 1ns/10ps
`default_nettype none
interface ead_cost_if;
	ead_pkg::ead_size_e size;
	ead_pkg::ead_bus_e bus;
	logic odd;
	logic [3:0] cycles;
	logic [2:0] accesses;
	modport requester (output size, output bus, output odd,
		input cycles, input accesses);
	modport provider (input size, input bus, input odd,
		output cycles, output accesses);
endinterface
`default_nettype wire

/* File: shared/ead_pkg.sv */
// Package: constants and types for the effective-address decoder
package ead_pkg;
	localparam int EA_W = 5;
	localparam int DATA_W = 16;
	localparam logic [4:0] EA_REG_LAST = 5'h07;
	localparam logic [4:0] EA_IND_FIRST = 5'h08;
	localparam logic [4:0] EA_IND_LAST = 5'h0b;
	localparam logic [4:0] EA_INC_FIRST = 5'h0c;
	localparam logic [4:0] EA_INC_LAST = 5'h0f;
	localparam logic [4:0] EA_D8_FIRST = 5'h10;
	localparam logic [4:0] EA_D8_LAST = 5'h17;
	localparam logic [4:0] EA_D16_FIRST = 5'h18;
	localparam logic [4:0] EA_D16_LAST = 5'h1b;
	localparam logic [4:0] EA_IDX0 = 5'h1c;
	localparam logic [4:0] EA_IDX1 = 5'h1d;
	localparam logic [4:0] EA_PCREL = 5'h1e;
	localparam logic [4:0] EA_DIRECT = 5'h1f;
	localparam logic [2:0] INDEX_REG_NUM = 3'h7;
	// Extension byte counts
	localparam logic [1:0] EXT_NONE = 2'h0;
	localparam logic [1:0] EXT_ONE = 2'h1;
	localparam logic [1:0] EXT_TWO = 2'h2;
	// Address and operand cycles, register and operand accesses, operand sizes in bytes
	localparam logic [3:0] CYC_ONE = 4'h1;
	localparam logic [3:0] CYC_TWO = 4'h2;
	localparam logic [3:0] CYC_FOUR = 4'h4;
	localparam logic [3:0] CYC_EIGHT = 4'h8;
	localparam logic [3:0] CYC_ZERO = 4'h0;
	localparam logic [2:0] ACC_ZERO = 3'h0;
	localparam logic [2:0] ACC_ONE = 3'h1;
	localparam logic [2:0] ACC_TWO = 3'h2;
	localparam logic [2:0] ACC_FOUR = 3'h4;
	localparam logic [2:0] SIZE_BYTE = 3'h1;
	localparam logic [2:0] SIZE_WORD = 3'h2;
	localparam logic [2:0] SIZE_LONG = 3'h4;

	typedef enum logic [3:0] {
		EAD_MODE_REG = 4'h0,
		EAD_MODE_IND = 4'h1,
		EAD_MODE_POSTINC = 4'h2,
		EAD_MODE_SDISP = 4'h3,
		EAD_MODE_LDISP = 4'h4,
		EAD_MODE_INDEX = 4'h5,
		EAD_MODE_PCREL = 4'h6,
		EAD_MODE_DIRECT = 4'h7
	} ead_mode_e;

	typedef enum logic [1:0] {
		EAD_SZ_BYTE = 2'h0,
		EAD_SZ_WORD = 2'h1,
		EAD_SZ_LONG = 2'h2
	} ead_size_e;

	typedef enum logic [1:0] {
		EAD_BUS_INTREG = 2'h0,
		EAD_BUS_INTMEM = 2'h1,
		EAD_BUS_EXT16 = 2'h2,
		EAD_BUS_EXT8 = 2'h3
	} ead_bus_e;
endpackage
